//--- verilog/slcg_ctrl.sv
// sleep-mode clock gating controller top
// Function
// R1: idle stops cpu, keeps sram timers spi irq
// R2: power-down stops oscillator, keeps registers
// R3: power-save keeps asynchronous timer running
// R4: adc noise reduction keeps adc, async timer
// R5: standby keeps rc oscillator running
// R6: extended standby keeps rc oscillator, async timer
// R7: deep sleep cuts logic, optional always-on keeps
// R8: seven software selectable sleep modes
// R9: software selects mode then requests sleep
// R10: interrupt or reset wakes, restores clocks
`timescale 1ns/10ps
`include "slcg_map.svh"
module slcg_ctrl (
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   input  wire logic [2:0]        i_sel,
   input  wire logic              i_sel_we,
   input  wire logic              i_sleep_req,
   input  wire logic              i_keep_wdt,
   input  wire logic              i_keep_symc,
   input  wire logic              i_keep_xosc,
   input  wire logic              i_irq,
   output slcg_pkg::slcg_gate_t   o_gates,
   output logic                   o_asleep,
   output logic                   o_wake,
   output logic                   o_refused
);
   // controller state and the latched sleep selection
   slcg_pkg::slcg_state_e state;
   slcg_pkg::slcg_state_e next_state;
   logic [2:0]            sel;
   logic [2:0]            next_sel;

   // always-on requests: pins, frozen copy, and what the decode sees
   logic [2:0]            keep_live;
   logic [2:0]            keep_held;
   logic [2:0]            next_keep_held;
   logic [2:0]            keep_use;

   // decoded mode and the enables that follow from it
   slcg_pkg::slcg_gate_t  dec_gates;
   logic                  dec_valid;
   slcg_pkg::slcg_gate_t  next_gates;

   // qualified events and flags derived from the state
   logic                  is_active;
   logic                  is_asleep;
   logic                  sel_load;
   logic                  take_req;
   logic                  refuse_req;
   logic                  wake_evt;
   logic                  enter_sleep;
   logic                  enter_wake;

   // next values of the status outputs
   logic                  next_asleep;
   logic                  next_wake;
   logic                  next_refused;

   // state flags decoded once so every rule below reads the same view
   assign is_active = (state == slcg_pkg::SLCG_ACTIVE);
   assign is_asleep = (state == slcg_pkg::SLCG_SLEEP);

   // a code written while asleep is dropped so the running mode cannot shift
   assign sel_load = i_sel_we && !is_asleep;

   // an interrupt in the request cycle blocks entry: wake beats sleep
   assign take_req   = i_sleep_req && is_active && dec_valid && !i_irq;  // R9
   assign refuse_req = i_sleep_req && is_active && !dec_valid;           // R8
   assign wake_evt   = is_asleep && i_irq;                               // R10

   // pin order matches the bit order of the frozen copy
   assign keep_live = {i_keep_xosc, i_keep_symc, i_keep_wdt};

   // the decode sees the frozen requests while asleep, the pins otherwise
   assign keep_use = is_asleep ? keep_held : keep_live;

   // seven codes decode to modes, the rest are refused
   slcg_mode_decode slcg_mode_decode_inst (
      .i_sel       (sel),
      .i_keep_wdt  (keep_use[0]),
      .i_keep_symc (keep_use[1]),
      .i_keep_xosc (keep_use[2]),
      .o_gates     (dec_gates),
      .o_valid     (dec_valid)
   );  // R8

   // next mode code: hold unless a write is accepted
   always_comb begin
      next_sel = sel;
      if (sel_load) begin
         next_sel = i_sel;  // R9
      end else begin
         next_sel = sel;
      end
   end

   // selection is latched; it does nothing until a sleep request
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sel <= `SLCG_SEL_RESET;
      end else begin
         sel <= next_sel;
      end
   end

   // requests frozen at entry: a pin that moves mid-sleep cannot stop
   // a domain that software asked to keep; new values count next sleep
   always_comb begin
      next_keep_held = keep_held;
      if (take_req) begin
         next_keep_held = keep_live;  // R7
      end else begin
         next_keep_held = keep_held;
      end
   end

   // frozen always-on requests
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         keep_held <= `SLCG_KEEP_RESET;
      end else begin
         keep_held <= next_keep_held;
      end
   end

   // wake beats a sleep request in the same cycle so no interrupt is lost
   always_comb begin
      next_state = state;
      case (state)
         slcg_pkg::SLCG_ACTIVE: begin
            if (take_req) begin
               next_state = slcg_pkg::SLCG_SLEEP;  // R9
            end else begin
               next_state = slcg_pkg::SLCG_ACTIVE;
            end
         end
         slcg_pkg::SLCG_SLEEP: begin
            if (wake_evt) begin
               next_state = slcg_pkg::SLCG_WAKE;  // R10
            end else begin
               next_state = slcg_pkg::SLCG_SLEEP;  // R2
            end
         end
         slcg_pkg::SLCG_WAKE: begin
            // one fully clocked cycle before code runs again
            next_state = slcg_pkg::SLCG_ACTIVE;  // R10
         end
         default: begin
            // an illegal code recovers to the safe, fully clocked state
            next_state = slcg_pkg::SLCG_ACTIVE;
         end
      endcase
   end

   // controller state; any reset lands fully awake
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= slcg_pkg::SLCG_ACTIVE;  // R10
      end else begin
         state <= next_state;
      end
   end

   // where the next edge goes decides both the enables and the status
   assign enter_sleep = (next_state == slcg_pkg::SLCG_SLEEP);
   assign enter_wake  = (next_state == slcg_pkg::SLCG_WAKE);

   // one enable per domain: the decoded value in sleep, on otherwise;
   // a loop keeps the per-domain logic uniform as domains are added
   genvar dom;
   generate
      for (dom = 0; dom < `SLCG_GATES; dom = dom + 1) begin : g_dom
         assign next_gates[dom] = enter_sleep ? dec_gates[dom] : 1'b1;  // R1
      end
   endgenerate

   // gate vector registered: glitch-free enables for the clock gates
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_gates <= `SLCG_ALL_ON;  // R10
      end else begin
         o_gates <= next_gates;
      end
   end

   // status next values; the wake pulse lasts one cycle as the state moves on, refusal stays high while the request is held
   always_comb begin
      next_asleep  = enter_sleep;
      next_wake    = enter_wake;
      next_refused = refuse_req;  // R8
   end

   // sleep flag, high for as long as a mode is held
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_asleep <= 1'b0;
      end else begin
         o_asleep <= next_asleep;
      end
   end

   // wake pulse: the cycle after the interrupt, every domain back on
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= next_wake;  // R10
      end
   end

   // refusal pulse for a reserved code; the request itself is dropped,
   // so software must write a valid code and ask again
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_refused <= 1'b0;
      end else begin
         o_refused <= next_refused;
      end
   end
endmodule : slcg_ctrl

//--- pkg/slcg_map.svh
// constants for the sleep-mode clock gating controller
`ifndef SLCG_MAP_SVH
`define SLCG_MAP_SVH
`define SLCG_SEL_IDLE      3'h0
`define SLCG_SEL_ADC_NR    3'h1
`define SLCG_SEL_PWR_DOWN  3'h2
`define SLCG_SEL_PWR_SAVE  3'h3
`define SLCG_SEL_STANDBY   3'h6
`define SLCG_SEL_EXT_STBY  3'h7
`define SLCG_SEL_DEEP      3'h5
`define SLCG_SEL_RESET     3'h0
`define SLCG_KEEP_RESET    3'h0
// gate vector bit positions
`define SLCG_G_CPU    0
`define SLCG_G_SRAM   1
`define SLCG_G_TMR    2
`define SLCG_G_SPI    3
`define SLCG_G_IRQ    4
`define SLCG_G_ADC    5
`define SLCG_G_ASYNC  6
`define SLCG_G_RCOSC  7
`define SLCG_G_MAIN   8
`define SLCG_G_WDT    9
`define SLCG_G_SYMC   10
`define SLCG_G_XOSC32 11
`define SLCG_G_LOGIC  12
`define SLCG_GATES    13
`define SLCG_ALL_ON   13'h1FFF
`endif

//--- pkg/slcg_pkg.sv
// types for the sleep-mode clock gating controller
package slcg_pkg;
   typedef enum logic [2:0] {
      SLCG_ACTIVE = 3'h1,
      SLCG_SLEEP  = 3'h2,
      SLCG_WAKE   = 3'h4
   } slcg_state_e;
   typedef logic [12:0] slcg_gate_t;
endpackage : slcg_pkg

//--- verilog/slcg_mode_decode.sv
// decode of a sleep selection into the set of domains that stay enabled
`timescale 1ns/10ps
`include "slcg_map.svh"
module slcg_mode_decode (
   input  wire logic [2:0]         i_sel,
   input  wire logic               i_keep_wdt,
   input  wire logic               i_keep_symc,
   input  wire logic               i_keep_xosc,
   output slcg_pkg::slcg_gate_t    o_gates,
   output logic                    o_valid
);
   // every domain not listed is stopped; register contents are retained by not cutting logic
   always_comb begin
      o_gates = '0;
      o_valid = 1'b1;
      o_gates[`SLCG_G_LOGIC] = 1'b1;          // retention held in every mode but deep sleep
      o_gates[`SLCG_G_WDT]   = i_keep_wdt;   // watchdog runs on its own oscillator
      case (i_sel)
         `SLCG_SEL_IDLE: begin
            o_gates[`SLCG_G_MAIN] = 1'b1;
            o_gates[`SLCG_G_SRAM] = 1'b1;     // R1
            o_gates[`SLCG_G_TMR]  = 1'b1;
            o_gates[`SLCG_G_SPI]  = 1'b1;
            o_gates[`SLCG_G_IRQ]  = 1'b1;
            o_gates[`SLCG_G_ADC]  = 1'b1;
            o_gates[`SLCG_G_ASYNC] = 1'b1;
         end
         `SLCG_SEL_ADC_NR: begin
            o_gates[`SLCG_G_MAIN]  = 1'b1;
            o_gates[`SLCG_G_ADC]   = 1'b1;    // R4
            o_gates[`SLCG_G_ASYNC] = 1'b1;    // R4
            o_gates[`SLCG_G_IRQ]   = 1'b1;
         end
         `SLCG_SEL_PWR_DOWN: begin
            o_gates[`SLCG_G_IRQ] = 1'b1;      // R2
         end
         `SLCG_SEL_PWR_SAVE: begin
            o_gates[`SLCG_G_IRQ]   = 1'b1;
            o_gates[`SLCG_G_ASYNC] = 1'b1;    // R3
         end
         `SLCG_SEL_STANDBY: begin
            o_gates[`SLCG_G_IRQ]   = 1'b1;
            o_gates[`SLCG_G_RCOSC] = 1'b1;    // R5
         end
         `SLCG_SEL_EXT_STBY: begin
            o_gates[`SLCG_G_IRQ]   = 1'b1;
            o_gates[`SLCG_G_RCOSC] = 1'b1;    // R6
            o_gates[`SLCG_G_ASYNC] = 1'b1;    // R6
         end
         `SLCG_SEL_DEEP: begin
            o_gates[`SLCG_G_LOGIC]  = 1'b0;   // R7
            o_gates[`SLCG_G_IRQ]    = 1'b1;
            o_gates[`SLCG_G_SYMC]   = i_keep_symc;
            o_gates[`SLCG_G_XOSC32] = i_keep_xosc;
         end
         default: begin
            // reserved code: refuse the request, nothing is gated
            o_gates = `SLCG_ALL_ON;
            o_valid = 1'b0;
         end
      endcase
   end
endmodule : slcg_mode_decode

//--- dv/slcg_ctrl_checker.sv
// assertions for the sleep-mode clock gating controller
`timescale 1ns/10ps
`include "slcg_map.svh"
module slcg_ctrl_checker (
   input wire logic                 i_mclk,
   input wire logic                 i_rst,
   input wire logic [2:0]           i_sel,
   input wire logic                 i_sel_we,
   input wire logic                 i_sleep_req,
   input wire logic                 i_irq,
   input wire slcg_pkg::slcg_gate_t o_gates,
   input wire logic                 o_asleep,
   input wire logic                 o_wake,
   input wire logic                 o_refused
);
   logic [2:0] sel_q;
   // shadow of the latched code; writes during sleep are dropped
   always_ff @(posedge i_mclk) begin
      if (i_rst) sel_q <= 3'h0;
      else if (i_sel_we && !o_asleep) sel_q <= i_sel;
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_take; i_sleep_req && !o_asleep && !o_wake && !i_irq; endsequence
   property p_enter; s_take ##0 sel_q != 3'h4 |=> o_asleep; endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered");
   property p_refuse; s_take ##0 sel_q == 3'h4 |=> o_refused && !o_asleep; endproperty
   a_refuse: assert property (p_refuse) else $error("reserved code slept");
   property p_wake; o_asleep && i_irq |=> o_wake && !o_asleep && o_gates == `SLCG_ALL_ON;
   endproperty
   a_wake: assert property (p_wake) else $error("wake failed");
   property p_pulse; o_wake || o_refused |=> !(o_wake || o_refused); endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_awake; !o_asleep |-> o_gates == `SLCG_ALL_ON; endproperty
   a_awake: assert property (p_awake) else $error("gated while awake");
   property p_cpu; o_asleep |-> !o_gates[`SLCG_G_CPU] && o_gates[`SLCG_G_IRQ]; endproperty
   a_cpu: assert property (p_cpu) else $error("cpu or irq gate wrong");
   property p_hold; o_asleep && !i_irq |=> o_asleep && $stable(o_gates); endproperty
   a_hold: assert property (p_hold) else $error("sleep not held");
   property p_rst; disable iff (1'b0) i_rst |=> o_gates == `SLCG_ALL_ON && !o_asleep;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : slcg_ctrl_checker
bind slcg_ctrl slcg_ctrl_checker slcg_ctrl_checker_inst (
   .i_mclk      (i_mclk),
   .i_rst       (i_rst),
   .i_sel       (i_sel),
   .i_sel_we    (i_sel_we),
   .i_sleep_req (i_sleep_req),
   .i_irq       (i_irq),
   .o_gates     (o_gates),
   .o_asleep    (o_asleep),
   .o_wake      (o_wake),
   .o_refused   (o_refused)
);

//--- dv/slcg_ctrl_tb_top.sv
// self-checking bench for the sleep-mode clock gating controller
`timescale 1ns/10ps
`include "slcg_map.svh"
module slcg_ctrl_tb_top;
   logic i_mclk = 0, i_rst = 1, i_sel_we = 0, i_sleep_req = 0, i_irq = 0;
   logic i_keep_wdt = 0, i_keep_symc = 0, i_keep_xosc = 0;
   logic [2:0] i_sel = 3'h0;
   slcg_pkg::slcg_gate_t o_gates;
   logic o_asleep, o_wake, o_refused;
   int fail_count = 0, check_count = 0;
   // code, mask of bits the mode fixes, and their values
   logic [2:0] mc [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h5};
   logic [12:0] mm [7] = '{13'h1F, 13'h6D, 13'h1FFF, 13'h1FFF, 13'hC1, 13'hC1, 13'h1E01};
   logic [12:0] mv [7] = '{13'h1E, 13'h60, 13'h1010, 13'h1050, 13'h80, 13'hC0, 13'hE00};
   always #2 i_mclk = ~i_mclk;
   slcg_ctrl slcg_ctrl_inst (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_sel       (i_sel),
      .i_sel_we    (i_sel_we),
      .i_sleep_req (i_sleep_req),
      .i_keep_wdt  (i_keep_wdt),
      .i_keep_symc (i_keep_symc),
      .i_keep_xosc (i_keep_xosc),
      .i_irq       (i_irq),
      .o_gates     (o_gates),
      .o_asleep    (o_asleep),
      .o_wake      (o_wake),
      .o_refused   (o_refused)
   );
   // wide enough for the status bits packed above the gate vector
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // optional code write, then a request one cycle later
   task automatic go(input logic [2:0] code, input logic we, input logic irq);
      @(posedge i_mclk);
      i_sel <= code;
      i_sel_we <= we;
      @(posedge i_mclk);
      i_sel_we <= 1'b0;
      i_sleep_req <= 1'b1;
      i_irq <= irq;
      @(posedge i_mclk);
      i_sleep_req <= 1'b0;
      i_irq <= 1'b0;
      #1;
   endtask : go
   task automatic wake;
      @(posedge i_mclk);
      i_irq <= 1'b1;
      @(posedge i_mclk);
      i_irq <= 1'b0;
      #1;
      chk({o_wake, o_asleep, o_gates}, {2'b10, `SLCG_ALL_ON});
      @(posedge i_mclk);
      #1;
      chk(o_wake, 1'b0);
   endtask : wake
   task automatic t_modes;
      for (int i = 0; i < 7; i++) begin
         @(posedge i_mclk);
         {i_keep_wdt, i_keep_symc, i_keep_xosc} <= {3{i == 6}};
         go(mc[i], 1'b1, 1'b0);
         chk({o_asleep, o_gates & mm[i]}, {1'b1, mv[i]});
         repeat (3) @(posedge i_mclk);
         wake();
      end
      @(posedge i_mclk);
      i_keep_wdt <= 1'b0;
      {i_keep_symc, i_keep_xosc} <= 2'b00;
   endtask : t_modes
   // reserved code, irq race, and a write while asleep
   task automatic t_refuse;
      go(3'h4, 1'b1, 1'b0);
      chk({o_refused, o_asleep}, 2'b10);
      go(3'h2, 1'b1, 1'b1);
      chk(o_asleep, 1'b0);
      go(3'h2, 1'b0, 1'b0);
      @(posedge i_mclk);
      i_sel <= 3'h0;
      i_sel_we <= 1'b1;
      @(posedge i_mclk);
      i_sel_we <= 1'b0;
      wake();
      go(3'h0, 1'b0, 1'b0);
      chk(o_gates, 13'h1010);
      wake();
   endtask : t_refuse
   // reset in mid-sleep: all domains back on, code back to idle
   task automatic t_reset;
      go(3'h3, 1'b1, 1'b0);
      chk({o_asleep, o_gates}, {1'b1, 13'h1050});
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk({o_wake, o_asleep, o_gates}, {2'b00, `SLCG_ALL_ON});
      go(3'h2, 1'b0, 1'b0);
      chk({o_asleep, o_gates & 13'h1F}, {1'b1, 13'h1E});
      wake();
   endtask : t_reset
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk({o_asleep, o_gates}, {1'b0, `SLCG_ALL_ON});
      t_modes();
      t_refuse();
      t_reset();
      final_report();
   end
   // hang guard well beyond the hundred or so cycles the run needs
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
endmodule : slcg_ctrl_tb_top
